// ==== logic/ast_transceiver.sv ====
// Asynchronous serial transceiver with Avalon-MM register slave and baud generator.
//
// The Avalon-MM interface to the registers was decided locally.
`default_nettype none
module ast_transceiver (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic serial_tx_pin,
  output logic serial_tx_oe,
  input wire logic serial_rx_pin,
  output logic tx_irq,
  output logic rx_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: every access takes two cycles, the first latches read data.
  logic ack_reg;
  logic [7:0] rdata_reg;
  ast_pkg::ast_ctrl_t ctrl_reg;
  logic [7:0] div_reg;
  logic [7:0] status;
  logic [7:0] rx_data_reg;

  wire [11:0] reg_index = avs_address[13:2];
  wire hit_data = reg_index == ast_pkg::IDX_DATA;
  wire hit_status = reg_index == ast_pkg::IDX_STATUS;
  wire hit_ctrl = reg_index == ast_pkg::IDX_CONTROL;
  wire hit_div = reg_index == ast_pkg::IDX_DIVISOR;
  wire do_write = avs_write & ack_reg & avs_byteenable[0];
  wire do_read = avs_read & ack_reg;
  wire wr_data = do_write & hit_data;
  wire wr_ctrl = do_write & hit_ctrl;
  wire wr_div = do_write & hit_div;
  wire rd_data = do_read & hit_data;
  wire rd_status = do_read & hit_status;
  wire [7:0] rd_mux = hit_data ? rx_data_reg :
                      hit_status ? status :
                      hit_ctrl ? ctrl_reg :
                      hit_div ? div_reg : 8'h00;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = {24'h000000, rdata_reg};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= ast_pkg::CONTROL_RESET;
      div_reg <= ast_pkg::DIVISOR_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= avs_writedata[7:0];
      end
      if (wr_div) begin
        div_reg <= avs_writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator. A divisor of zero wraps to 256, giving clock/4096 per bit.
  // The generator never looks at any processor halt state.
  logic [7:0] div_cnt_reg;
  logic [3:0] sixteenth_reg;
  wire sample_tick = div_cnt_reg == 8'h00;
  wire bit_tick = sample_tick & (sixteenth_reg == ast_pkg::TICK_LAST);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 8'h00;
      sixteenth_reg <= 4'h0;
    end else if (sample_tick) begin
      div_cnt_reg <= div_reg - ast_pkg::DIV_ONE;
      sixteenth_reg <= sixteenth_reg + 4'h1;
    end else begin
      div_cnt_reg <= div_cnt_reg - ast_pkg::DIV_ONE;
    end
  end

  // Timer timeout flag, cleared by a status read; a timeout in that cycle wins.
  logic timer_flag_reg;
  wire timer_event = bit_tick & ~ctrl_reg.tx_en & ~ctrl_reg.rx_en;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_flag_reg <= 1'b0;
    end else if (timer_event) begin
      timer_flag_reg <= 1'b1;
    end else if (rd_status) begin
      timer_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  ast_pkg::ast_tx_state_t tx_state_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_bit_reg;
  logic tx_par_reg;
  logic tx_pin_reg;

  wire tx_load = ctrl_reg.tx_en & bit_tick & (tx_state_reg == ast_pkg::TX_IDLE) & hold_full_reg;
  wire tx_ready = ctrl_reg.tx_en & ~hold_full_reg;
  wire tx_done = ~hold_full_reg & (tx_state_reg == ast_pkg::TX_IDLE);

  assign serial_tx_pin = tx_pin_reg;
  assign serial_tx_oe = ctrl_reg.tx_en;
  assign tx_irq = ctrl_reg.tx_ie & tx_ready;

  // A write in the cycle of a move keeps the new byte held, while the old byte still goes to the shifter.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
    end else if (~ctrl_reg.tx_en) begin
      hold_full_reg <= 1'b0;
    end else if (wr_data) begin
      hold_reg <= avs_writedata[7:0];
      hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_state_reg <= ast_pkg::TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_bit_reg <= 3'h0;
      tx_par_reg <= 1'b0;
      tx_pin_reg <= 1'b1;
    end else if (~ctrl_reg.tx_en) begin
      tx_state_reg <= ast_pkg::TX_IDLE;
      tx_pin_reg <= 1'b1;
    end else if (bit_tick) begin
      unique case (tx_state_reg)
        ast_pkg::TX_IDLE: begin
          if (hold_full_reg) begin
            tx_shift_reg <= hold_reg;
            tx_par_reg <= (^hold_reg) ^ ctrl_reg.par_odd;
            tx_pin_reg <= 1'b0;
            tx_state_reg <= ast_pkg::TX_START;
          end
        end
        ast_pkg::TX_START: begin
          tx_pin_reg <= tx_shift_reg[0];
          tx_bit_reg <= 3'h0;
          tx_state_reg <= ast_pkg::TX_DATA;
        end
        ast_pkg::TX_DATA: begin
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_bit_reg <= tx_bit_reg + 3'h1;
          if (tx_bit_reg != ast_pkg::BIT_LAST) begin
            tx_pin_reg <= tx_shift_reg[1];
          end else if (ctrl_reg.par_en) begin
            tx_pin_reg <= tx_par_reg;
            tx_state_reg <= ast_pkg::TX_PARITY;
          end else begin
            tx_pin_reg <= 1'b1;
            tx_state_reg <= ast_pkg::TX_STOP1;
          end
        end
        ast_pkg::TX_PARITY: begin
          tx_pin_reg <= 1'b1;
          tx_state_reg <= ast_pkg::TX_STOP1;
        end
        ast_pkg::TX_STOP1: begin
          tx_state_reg <= ctrl_reg.two_stop ? ast_pkg::TX_STOP2 : ast_pkg::TX_IDLE;
        end
        ast_pkg::TX_STOP2: begin
          tx_state_reg <= ast_pkg::TX_IDLE;
        end
        default: begin
          tx_state_reg <= ast_pkg::TX_IDLE;
          tx_pin_reg <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive line: two-stage synchroniser, then an optional glitch filter that
  // needs three equal sample ticks in a row before the level is believed.
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_filt_reg;
  logic [1:0] filt_cnt_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_filt_reg <= 1'b1;
      filt_cnt_reg <= 2'h0;
    end else if (sample_tick) begin
      if (rx_sync_reg == rx_filt_reg) begin
        filt_cnt_reg <= 2'h0;
      end else if (filt_cnt_reg == ast_pkg::FILTER_LAST) begin
        rx_filt_reg <= rx_sync_reg;
        filt_cnt_reg <= 2'h0;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 2'h1;
      end
    end
  end

  wire rx_line = ctrl_reg.filter_en ? rx_filt_reg : rx_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver.
  ast_pkg::ast_rx_state_t rx_state_reg;
  logic [3:0] rx_tick_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_zero_reg;
  logic rx_perr_reg;
  logic rx_full_reg;
  logic fe_reg;
  logic pe_reg;
  logic ovr_reg;
  logic brk_reg;

  wire rx_center = sample_tick & (rx_tick_reg == ast_pkg::TICK_LAST);
  wire rx_stop = rx_center & (rx_state_reg == ast_pkg::RX_STOP);
  wire stop_low = ~rx_line;
  wire is_break = rx_zero_reg & stop_low;
  wire store = rx_stop & ~rx_full_reg;
  wire overrun = rx_stop & rx_full_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= ast_pkg::RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_zero_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
    end else if (~ctrl_reg.rx_en) begin
      rx_state_reg <= ast_pkg::RX_IDLE;
    end else if (sample_tick) begin
      rx_tick_reg <= rx_tick_reg + 4'h1;
      unique case (rx_state_reg)
        ast_pkg::RX_IDLE: begin
          rx_tick_reg <= 4'h0;
          if (~rx_line) begin
            rx_state_reg <= ast_pkg::RX_START;
          end
        end
        ast_pkg::RX_START: begin
          if (rx_tick_reg == ast_pkg::TICK_HALF) begin
            rx_tick_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_zero_reg <= 1'b1;
            rx_perr_reg <= 1'b0;
            rx_state_reg <= rx_line ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
          end
        end
        ast_pkg::RX_DATA: begin
          if (rx_center) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            rx_zero_reg <= rx_zero_reg & ~rx_line;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == ast_pkg::BIT_LAST) begin
              rx_state_reg <= ctrl_reg.par_en ? ast_pkg::RX_PARITY : ast_pkg::RX_STOP;
            end
          end
        end
        ast_pkg::RX_PARITY: begin
          if (rx_center) begin
            rx_perr_reg <= (^{rx_shift_reg, rx_line}) != ctrl_reg.par_odd;
            rx_zero_reg <= rx_zero_reg & ~rx_line;
            rx_state_reg <= ast_pkg::RX_STOP;
          end
        end
        ast_pkg::RX_STOP: begin
          if (rx_center) begin
            rx_state_reg <= stop_low ? ast_pkg::RX_WAIT_HIGH : ast_pkg::RX_IDLE;
          end
        end
        ast_pkg::RX_WAIT_HIGH: begin
          if (rx_line) begin
            rx_state_reg <= ast_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= ast_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Flags clear on a data read; a character ending in that same cycle wins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
      ovr_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else if (rx_stop) begin
      if (store) begin
        rx_data_reg <= rx_shift_reg;
      end
      rx_full_reg <= 1'b1;
      fe_reg <= fe_reg | stop_low;
      pe_reg <= pe_reg | rx_perr_reg;
      ovr_reg <= ovr_reg | overrun;
      brk_reg <= brk_reg | is_break;
    end else if (rd_data) begin
      rx_full_reg <= 1'b0;
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
      ovr_reg <= 1'b0;
      brk_reg <= 1'b0;
    end
  end

  // Status byte assembled from live state; see the package for bit positions.
  always_comb begin
    status = 8'h00;
    status[ast_pkg::ST_RX_FULL] = rx_full_reg;
    status[ast_pkg::ST_FRAMING] = fe_reg;
    status[ast_pkg::ST_PARITY] = pe_reg;
    status[ast_pkg::ST_OVERRUN] = ovr_reg;
    status[ast_pkg::ST_BREAK] = brk_reg;
    status[ast_pkg::ST_TX_EMPTY] = tx_ready;
    status[ast_pkg::ST_TX_DONE] = tx_done;
    status[ast_pkg::ST_TIMER] = timer_flag_reg;
  end

  // The receive request also carries errors and the timer timeout.
  assign rx_irq = (ctrl_reg.rx_ie & rx_full_reg) | fe_reg | pe_reg | ovr_reg | brk_reg | timer_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_tx_idle_high: assert property ((tx_state_reg == ast_pkg::TX_IDLE) |-> serial_tx_pin)
    else $error("transmit line not high while idle");
  a_tx_start_low: assert property ((tx_state_reg == ast_pkg::TX_START) |-> !serial_tx_pin)
    else $error("start bit not low");
  a_tx_disable_quiet: assert property (!ctrl_reg.tx_en |=> serial_tx_pin && !hold_full_reg)
    else $error("transmitter active while disabled");
  a_hold_write_busy: assert property (wr_data && ctrl_reg.tx_en |=> !status[ast_pkg::ST_TX_EMPTY] && !tx_done)
    else $error("empty or done flag after holding write");
  a_overrun_keeps: assert property (overrun |=> $stable(rx_data_reg) && ovr_reg)
    else $error("overrun replaced unread data");
  a_rx_disabled: assert property (!ctrl_reg.rx_en |=> rx_state_reg == ast_pkg::RX_IDLE)
    else $error("receiver running while disabled");
  a_baud_period: assert property (sample_tick && div_reg == 8'h02 && !wr_div |=> !sample_tick ##1 sample_tick)
    else $error("sample tick period differs from divisor");
  a_tx_irq_now: assert property (ctrl_reg.tx_en && ctrl_reg.tx_ie && !hold_full_reg |-> tx_irq)
    else $error("transmit interrupt missing while empty");
  a_framing_flag: assert property (rx_stop && stop_low |=> fe_reg && rx_full_reg)
    else $error("framing error not flagged");
  a_bus_wait: assert property ((avs_read || avs_write) && !ack_reg |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not on second cycle");

  c_tx_start: cover property (tx_load);
  c_rx_store: cover property (store);
  c_rx_overrun: cover property (overrun);
  c_timer: cover property (timer_event);

endmodule
`default_nettype wire

// ==== logic/ast_pkg.sv ====
// Shared constants, register map and types of the asynchronous serial transceiver.
`default_nettype none
package ast_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam int ADDR_W = 14;
  localparam logic [11:0] IDX_DATA = 12'h0f1;
  localparam logic [11:0] IDX_STATUS = 12'h0f2;
  localparam logic [11:0] IDX_CONTROL = 12'h0f3;
  localparam logic [11:0] IDX_DIVISOR = 12'h0f4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'hff;

  // Status bit positions.
  localparam int ST_RX_FULL = 7;
  localparam int ST_FRAMING = 6;
  localparam int ST_PARITY = 5;
  localparam int ST_OVERRUN = 4;
  localparam int ST_BREAK = 3;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_TX_DONE = 1;
  localparam int ST_TIMER = 0;

  // Control register layout, most significant bit first.
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic tx_ie;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic filter_en;
    logic rx_ie;
  } ast_ctrl_t;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: sixteen sample ticks per bit, the centre is the eighth.
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] DIV_ONE = 8'h01;
  localparam logic [1:0] FILTER_LAST = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h2,
    TX_PARITY = 3'h3,
    TX_STOP1 = 3'h4,
    TX_STOP2 = 3'h5
  } ast_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_PARITY = 3'h3,
    RX_STOP = 3'h4,
    RX_WAIT_HIGH = 3'h5
  } ast_rx_state_t;

endpackage
`default_nettype wire

// ==== sim/ast_remote.sv ====
// Remote serial partner: sends frames to the receiver and captures frames from the transmitter.
`default_nettype none
module ast_remote #(
  parameter int BIT_CYC = 32
) (
  input wire logic core_clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got_q[$];
  logic [8:0] word;

  initial line_out = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Parity and stop level come from the caller, so that broken frames can be made.
  task automatic send(input logic [7:0] d, input logic p_en, input logic p_val, input logic stop_v);
    logic [10:0] bits;
    int n;
    bits = p_en ? {stop_v, p_val, d, 1'b0} : {1'b1, stop_v, d, 1'b0};
    n = p_en ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
    line_out <= 1'b1;
    repeat (BIT_CYC) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Only data plus the next bit are kept, so a back-to-back start is never missed.
  // A low ninth bit, such as a parity zero, is waited out, so it is not taken for a start.
  always begin
    @(posedge core_clk);
    if (line_in === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        word[i] = line_in;
      end
      got_q.push_back(word);
      for (int k = 0; k < 2 * BIT_CYC && line_in !== 1'b1; k++) begin
        @(posedge core_clk);
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the serial transceiver: registers, transmit, receive and error flags.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  localparam logic [13:0] A_DATA = {ast_pkg::IDX_DATA, 2'b00};
  localparam logic [13:0] A_ST = {ast_pkg::IDX_STATUS, 2'b00};
  localparam logic [13:0] A_CTL = {ast_pkg::IDX_CONTROL, 2'b00};
  localparam logic [13:0] A_DIV = {ast_pkg::IDX_DIVISOR, 2'b00};
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic serial_tx_pin, serial_tx_oe, serial_rx_pin, tx_irq, rx_irq;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [3:0] avs_byteenable;
  wire logic tx_line;
  int fails, checked, waited;

  ast_transceiver dut_u (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serial_tx_pin(serial_tx_pin),
    .serial_tx_oe(serial_tx_oe), .serial_rx_pin(serial_rx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
  ast_remote #(.BIT_CYC(BIT)) remote_u (.core_clk(core_clk), .line_in(tx_line), .line_out(serial_rx_pin));
  // The transmit pin has a pull-up while it is not driven.
  assign tx_line = serial_tx_oe ? serial_tx_pin : 1'b1;

  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      close_out();
    end else begin
      @(posedge core_clk);
    end
  endtask

  task automatic rd_chk(input logic [13:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rdata, {24'h0, exp});
  endtask

  // The timer flag in bit 0 runs on its own, so it is left out here.
  task automatic st_chk(input logic [7:0] exp);
    bus(1'b0, A_ST, 8'h00);
    chk({25'h0, rdata[7:1]}, {25'h0, exp[7:1]});
  endtask

  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, A_ST, 8'h00);
      n++;
    end while (rdata[b] !== v && n < 2000);
    if (n >= 2000) begin
      chk({31'h0, rdata[b]}, {31'h0, v});
      close_out();
    end
  endtask

  task automatic pop_chk(input logic [8:0] exp);
    if (remote_u.got_q.size() == 0) chk(32'h200, {23'h0, exp});
    else chk({23'h0, remote_u.got_q.pop_front()}, {23'h0, exp});
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    chk(32'h1, 32'h0);
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    avs_address = 14'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    fails = 0;
    checked = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd_chk(A_ST, 8'h02);
    rd_chk(A_CTL, 8'h00);
    rd_chk(A_DIV, 8'hff);
    rd_chk(14'h0000, 8'h00);
    chk({31'h0, tx_line}, 32'h1);
    bus(1'b1, A_DIV, 8'h02);
    rd_chk(A_DIV, 8'h02);
    // A write without byte lane 0 must leave the divisor as it is.
    avs_byteenable <= 4'he;
    bus(1'b1, A_DIV, 8'h55);
    avs_byteenable <= 4'hf;
    rd_chk(A_DIV, 8'h02);
    $display("test reset_map done");
    bus(1'b1, A_DATA, 8'h66);
    repeat (12 * BIT) @(posedge core_clk);
    chk(remote_u.got_q.size(), 32'h0);
    bus(1'b0, A_ST, 8'h00);
    chk({31'h0, rdata[ast_pkg::ST_TIMER]}, 32'h1);
    st_chk(8'h02);
    $display("test tx_disabled done");
    bus(1'b1, A_CTL, 8'ha0);
    chk({30'h0, tx_irq, serial_tx_oe}, 32'h3);
    st_chk(8'h06);
    bus(1'b1, A_DATA, 8'h11);
    wait_st(ast_pkg::ST_TX_EMPTY, 1'b1);
    bus(1'b1, A_DATA, 8'h22);
    chk({31'h0, tx_irq}, 32'h0);
    st_chk(8'h00);
    bus(1'b1, A_DATA, 8'h5a);
    wait_st(ast_pkg::ST_TX_DONE, 1'b1);
    pop_chk(9'h111);
    pop_chk(9'h15a);
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, A_CTL, 8'h90 | (m[7:0] << 3));
      bus(1'b1, A_DATA, 8'h07);
      wait_st(ast_pkg::ST_TX_DONE, 1'b1);
      // Three ones in the data: even parity sends a one, odd parity a zero.
      pop_chk({~m[0], 8'h07});
    end
    // Two stop bits: a bit period after the frame is seen, the line is still in its second stop bit.
    bus(1'b1, A_CTL, 8'h84);
    bus(1'b1, A_DATA, 8'h0f);
    waited = 0;
    while (remote_u.got_q.size() == 0 && waited < 2000) begin
      @(posedge core_clk);
      waited++;
    end
    repeat (BIT) @(posedge core_clk);
    st_chk(8'h04);
    wait_st(ast_pkg::ST_TX_DONE, 1'b1);
    pop_chk(9'h10f);
    $display("test transmit done");
    bus(1'b1, A_CTL, 8'h41);
    remote_u.send(8'hc3, 1'b0, 1'b0, 1'b1);
    wait_st(ast_pkg::ST_RX_FULL, 1'b1);
    chk({31'h0, rx_irq}, 32'h1);
    rd_chk(A_DATA, 8'hc3);
    st_chk(8'h02);
    bus(1'b1, A_CTL, 8'h00);
    remote_u.send(8'h99, 1'b0, 1'b0, 1'b1);
    st_chk(8'h02);
    bus(1'b1, A_CTL, 8'h42);
    remote_u.send(8'ha5, 1'b0, 1'b0, 1'b1);
    wait_st(ast_pkg::ST_RX_FULL, 1'b1);
    rd_chk(A_DATA, 8'ha5);
    $display("test receive done");
    bus(1'b1, A_CTL, 8'h40);
    remote_u.send(8'h3c, 1'b0, 1'b0, 1'b0);
    st_chk(8'hc2);
    rd_chk(A_DATA, 8'h3c);
    st_chk(8'h02);
    remote_u.send(8'h12, 1'b0, 1'b0, 1'b1);
    remote_u.send(8'h34, 1'b0, 1'b0, 1'b1);
    st_chk(8'h92);
    rd_chk(A_DATA, 8'h12);
    remote_u.send(8'h00, 1'b0, 1'b0, 1'b0);
    st_chk(8'hca);
    rd_chk(A_DATA, 8'h00);
    bus(1'b1, A_CTL, 8'h50);
    remote_u.send(8'h07, 1'b1, 1'b0, 1'b1);
    st_chk(8'ha2);
    rd_chk(A_DATA, 8'h07);
    remote_u.send(8'h07, 1'b1, 1'b1, 1'b1);
    st_chk(8'h82);
    rd_chk(A_DATA, 8'h07);
    bus(1'b1, A_CTL, 8'h58);
    remote_u.send(8'h07, 1'b1, 1'b0, 1'b1);
    st_chk(8'h82);
    rd_chk(A_DATA, 8'h07);
    $display("test errors done");
    bus(1'b1, A_CTL, 8'hc0);
    fork
      remote_u.send(8'h81, 1'b0, 1'b0, 1'b1);
      bus(1'b1, A_DATA, 8'h3e);
    join
    wait_st(ast_pkg::ST_TX_DONE, 1'b1);
    rd_chk(A_DATA, 8'h81);
    pop_chk(9'h13e);
    $display("test full_duplex done");
    close_out();
  end
endmodule
`default_nettype wire
